// [logic/rivm_pkg.sv]
// Purpose: Constants and types for the reset and interrupt vector map
// Assumes: 100 MHz core clock, word-addressed program memory
// Notes: Notes on behaviour follow
//
// Notes on behaviour
// - All reset causes share vector 1 at address 0x0000 when fuse unprogrammed.
// - External irq zero at 0x0002, irq one at 0x0004, two words apart.
// - Pin-change irqs a, b, c at 0x0006, 0x0008, 0x000A.
// - Watchdog timeout irq at 0x000C, vector number 7.
// - Timer 2 compare A 0x000E, compare B 0x0010, overflow 0x0012.
// - Timer 1 capture, compare A, compare B, overflow at 0x0014..0x001A.
// - Timer 0 compare A 0x001C, compare B 0x001E, overflow 0x0020.
// - Serial transfer done irq at 0x0022.
// - Serial port rx 0x0024, buffer empty 0x0026, tx done 0x0028.
// - Converter 0x002A, eeprom 0x002C, comparator 0x002E, two-wire 0x0030, self-program 0x0032.
// - Programmed fuse starts execution at the boot reset address.
// - Fuse value 1 means unprogrammed, 0 means programmed.
// - Table select set adds boot section start to every interrupt vector offset.
// - Fuse alone picks reset address, select bit alone picks table base.
// - Select and change-enable bits live in control reg, reset to zero.
package rivm_pkg;

    localparam int RIVM_NUM_IRQ = 25;
    localparam int RIVM_ADDR_W = 14;
    localparam int RIVM_VEC_W = 5;

    // Reset address when the fuse is unprogrammed
    localparam logic [13:0] RIVM_RESET_APP = 14'h0000;
    // Boot section start; size decoding is outside this block
    localparam logic [13:0] RIVM_BOOT_START = 14'h1C00;
    // Offset of the first interrupt vector and spacing between vectors
    localparam logic [13:0] RIVM_VEC_FIRST = 14'h0002;
    localparam logic [13:0] RIVM_VEC_STEP = 14'h0002;
    localparam logic [13:0] RIVM_VEC_LAST = 14'h0032;
    // Fuse levels
    localparam logic RIVM_FUSE_UNPROG = 1'h1;
    // Control register bit positions and reset value
    localparam int RIVM_CTL_SEL_BIT = 1;
    localparam int RIVM_CTL_CHG_BIT = 0;
    localparam logic [7:0] RIVM_CTL_RESET = 8'h00;
    // Dispatch handshake timeout for the assertion helper
    localparam int RIVM_ACK_WAIT = 8;

    typedef enum logic [1:0] {
        RIVM_IDLE = 2'b00,
        RIVM_RESET_FETCH = 2'b01,
        RIVM_OFFER = 2'b10
    } rivm_state_t;

    // Request offered to the fetch unit
    typedef struct packed {
        logic valid;
        logic is_reset;
        logic [4:0] vec_idx;
        logic [13:0] addr;
    } rivm_fetch_t;

endpackage

// [logic/rivm_prio.sv]
// Purpose: Lowest-index pending request finder
// Assumes: Requests already masked by the enable logic
// Notes: Pure combinational
`timescale 1ns/10ps
`default_nettype none
module rivm_prio
(
    input wire logic [24:0] req_i,
    output logic any_o,
    output logic [4:0] idx_o
);
    import rivm_pkg::*;

    // Scan downward so the lowest set bit wins
    always_comb
    begin
        any_o = 1'b0;
        idx_o = 5'h00;
        for (int i = RIVM_NUM_IRQ - 1; i >= 0; i--)
        begin
            if (req_i[i])
            begin
                any_o = 1'b1;
                idx_o = 5'(i);
            end
        end
    end
endmodule
`default_nettype wire

// [logic/rivm_addr.sv]
// Purpose: Vector index to program address
// Assumes: Table base chosen by the caller
// Notes: Combinational; index 0 is the first interrupt vector
`timescale 1ns/10ps
`default_nettype none
module rivm_addr
(
    input wire logic [13:0] base_i,
    input wire logic [4:0] idx_i,
    output logic [13:0] addr_o
);
    import rivm_pkg::*;

    // Offsets run from 0x0002 in steps of two words
    assign addr_o = 14'(base_i + RIVM_VEC_FIRST + 14'(idx_i) * RIVM_VEC_STEP);
endmodule
`default_nettype wire

// [logic/rivm_top.sv]
// Purpose: Reset and interrupt vector map for the CPU fetch unit
// Assumes: Requests come from same-clock peripheral logic, already enabled
// Notes: Fuse and control writes arrive from core logic on this clock
`timescale 1ns/10ps
`default_nettype none
module rivm_top
(
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic boot_reset_fuse_i,
    input wire logic [24:0] irq_req_i,
    input wire logic global_irq_en_i,
    input wire logic fetch_ack_i,
    input wire logic ctl_we_i,
    input wire logic [7:0] ctl_wdata_i,
    output rivm_pkg::rivm_fetch_t fetch_o,
    output logic [7:0] mcu_control_reg_o
);
    import rivm_pkg::*;

    // --------------------------------------------------------------
    // State and registers
    // --------------------------------------------------------------
    rivm_state_t state_q;
    rivm_state_t state_d;
    rivm_fetch_t fetch_q;
    logic [7:0] ctl_q;
    logic fuse_q;
    logic prio_any;
    logic [4:0] prio_idx;
    logic [13:0] table_base;
    logic [13:0] vec_addr;
    logic [13:0] reset_addr;
    logic vector_table_select;

    assign vector_table_select = ctl_q[RIVM_CTL_SEL_BIT];

    // Fuse sampled by a clocked process while reset is held
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
            fuse_q <= boot_reset_fuse_i;
    end

    // Control register, cleared at reset so the table starts in app space
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
            ctl_q <= RIVM_CTL_RESET;
        else if (ctl_we_i)
            ctl_q <= ctl_wdata_i & 8'h03;
    end

    // --------------------------------------------------------------
    // Address selection
    // --------------------------------------------------------------
    // Reset address from the fuse alone, table base from select alone
    assign reset_addr = (fuse_q == RIVM_FUSE_UNPROG) ? RIVM_RESET_APP
                                                      : RIVM_BOOT_START;
    assign table_base = vector_table_select ? RIVM_BOOT_START : 14'h0000;

    rivm_prio u_prio
    (
        .req_i(irq_req_i & {RIVM_NUM_IRQ{global_irq_en_i}}),
        .any_o(prio_any),
        .idx_o(prio_idx)
    );

    rivm_addr u_addr
    (
        .base_i(table_base),
        .idx_i(prio_idx),
        .addr_o(vec_addr)
    );

    // --------------------------------------------------------------
    // Dispatch state machine
    // --------------------------------------------------------------
    // Reset fetch first, then only real requests are offered
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            RIVM_RESET_FETCH:
                if (fetch_ack_i)
                    state_d = RIVM_IDLE;
            RIVM_IDLE:
                if (prio_any)
                    state_d = RIVM_OFFER;
            RIVM_OFFER:
                if (fetch_ack_i)
                    state_d = RIVM_IDLE;
            default:
                state_d = RIVM_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
            state_q <= RIVM_RESET_FETCH;
        else
            state_q <= state_d;
    end

    // Fetch request register; held stable while offered
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
            fetch_q <= '0;
        else if (state_q == RIVM_RESET_FETCH)
        begin
            fetch_q.valid <= !fetch_ack_i;
            fetch_q.is_reset <= 1'b1;
            fetch_q.vec_idx <= 5'h00;
            fetch_q.addr <= reset_addr;
        end
        else if (state_q == RIVM_IDLE && prio_any)
        begin
            fetch_q.valid <= 1'b1;
            fetch_q.is_reset <= 1'b0;
            fetch_q.vec_idx <= prio_idx;
            fetch_q.addr <= vec_addr;
        end
        else if (state_q == RIVM_OFFER && fetch_ack_i)
            fetch_q.valid <= 1'b0;
    end

    assign fetch_o = fetch_q;
    assign mcu_control_reg_o = ctl_q;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    // Interrupt offer standing toward the fetch unit
    sequence offer_s;
        fetch_q.valid && !fetch_q.is_reset;
    endsequence

    // Reset fetch standing toward the fetch unit
    sequence boot_s;
        fetch_q.valid && fetch_q.is_reset;
    endsequence

    // Any offer taken at this edge
    sequence take_s;
        fetch_q.valid && fetch_ack_i;
    endsequence

    // Address follows base plus two words per index
    vec_spacing_a: assert property (offer_s |-> fetch_q.addr ==
        14'((fetch_q.addr >= RIVM_BOOT_START ? RIVM_BOOT_START : 14'h0000)
        + 14'h0002 + 14'(fetch_q.vec_idx) * 14'h0002))
        else $error("vector address does not match index");

    // Only the documented sources are ever offered
    vec_range_a: assert property (offer_s |-> fetch_q.vec_idx <= 5'h18)
        else $error("vector index out of range");

    // Reset address picked by the fuse level
    reset_addr_a: assert property (boot_s |->
        fetch_q.addr == (fuse_q ? 14'h0000 : 14'h1C00))
        else $error("reset address disagrees with fuse");

    // Loaded index is the one the finder chose
    prio_low_a: assert property (state_q == RIVM_IDLE && prio_any |=>
        fetch_q.vec_idx == $past(prio_idx) && !fetch_q.is_reset)
        else $error("lowest pending not chosen");

    // Nothing is offered without a request
    no_spurious_a: assert property (state_q == RIVM_IDLE && !prio_any |=>
        !fetch_q.valid || fetch_q.is_reset)
        else $error("fetch offered without request");

    // Offered address stands until taken
    hold_offer_a: assert property ((offer_s and !fetch_ack_i) |=>
        $stable(fetch_q.addr))
        else $error("offered address moved before ack");

    // Control register clear on leaving reset
    ctl_reset_a: assert property ($rose(rstn_i) |-> ctl_q == 8'h00)
        else $error("control register not cleared");

    // Boot table base applied while select is set
    base_sel_a: assert property ((offer_s and
        (vector_table_select && $stable(vector_table_select)))
        |-> fetch_q.addr >= 14'h1C02)
        else $error("boot table base not applied");

    // Offset half of the address against the written-out table
    vec_table_a: assert property (offer_s |->
        fetch_q.addr[9:0] == table_ofs(fetch_q.vec_idx))
        else $error("vector offset disagrees with table");

    // Base half of the address is either table start
    base_half_a: assert property (offer_s |->
        fetch_q.addr[13:10] == 4'h0 || fetch_q.addr[13:10] == 4'h7)
        else $error("vector base is neither table start");

    // Programmed fuse starts in the boot section
    boot_reset_a: assert property ((boot_s and !fuse_q) |->
        fetch_q.addr == 14'h1C00)
        else $error("boot reset address not used");

    // First thing after reset is the reset fetch
    first_fetch_a: assert property ($rose(rstn_i) |=> fetch_q.is_reset)
        else $error("reset fetch not first");

    // Reset fetch stands until taken
    boot_hold_a: assert property ((boot_s and !fetch_ack_i) |=>
        fetch_q.valid && fetch_q.is_reset)
        else $error("reset fetch dropped before ack");

    // Taken offer is withdrawn at once
    take_drop_a: assert property (take_s |=> !fetch_q.valid)
        else $error("offer still standing after ack");

    // Global disable keeps the idle machine quiet
    masked_a: assert property (state_q == RIVM_IDLE && !global_irq_en_i |=>
        !fetch_q.valid)
        else $error("offer made while requests disabled");

    // Unused control bits always read zero
    ctl_mask_a: assert property (ctl_q[7:2] == 6'h00)
        else $error("unused control bits set");

    // Machine never leaves its three states
    state_legal_a: assert property (state_q == RIVM_IDLE ||
        state_q == RIVM_RESET_FETCH || state_q == RIVM_OFFER)
        else $error("dispatch state illegal");

    // One lowest-first check per request line
    for (genvar g = 0; g < RIVM_NUM_IRQ; g++)
    begin : g_prio_chk
        prio_bit_a: assert property (state_q == RIVM_IDLE && prio_any &&
            prio_idx == 5'(g) |-> irq_req_i[g] && global_irq_en_i
            && (irq_req_i & ((25'h1 << g) - 25'h1)) == 25'h0)
            else $error("pending line skipped by priority");
    end

    // --------------------------------------------------------------
    // Offset table for the checks
    // --------------------------------------------------------------
    // Written out per source so the adder is checked against a table
    // that does not share its arithmetic
    function automatic logic [9:0] table_ofs(input logic [4:0] idx);
        logic [9:0] ofs;
        ofs = 10'h3FF;
        case (idx)
            // External requests
            5'h00: ofs = 10'h002;
            5'h01: ofs = 10'h004;
            // Pin-change requests
            5'h02: ofs = 10'h006;
            5'h03: ofs = 10'h008;
            5'h04: ofs = 10'h00A;
            // Watchdog timeout
            5'h05: ofs = 10'h00C;
            // 8-bit timer 2
            5'h06: ofs = 10'h00E;
            5'h07: ofs = 10'h010;
            5'h08: ofs = 10'h012;
            // 16-bit timer 1
            5'h09: ofs = 10'h014;
            5'h0A: ofs = 10'h016;
            5'h0B: ofs = 10'h018;
            5'h0C: ofs = 10'h01A;
            // 8-bit timer 0
            5'h0D: ofs = 10'h01C;
            5'h0E: ofs = 10'h01E;
            5'h0F: ofs = 10'h020;
            // Serial peripheral
            5'h10: ofs = 10'h022;
            // Serial port
            5'h11: ofs = 10'h024;
            5'h12: ofs = 10'h026;
            5'h13: ofs = 10'h028;
            // Converter, eeprom, comparator, two-wire, self-program
            5'h14: ofs = 10'h02A;
            5'h15: ofs = 10'h02C;
            5'h16: ofs = 10'h02E;
            5'h17: ofs = 10'h030;
            5'h18: ofs = 10'h032;
            default: ofs = 10'h3FF;
        endcase
        return ofs;
    endfunction
endmodule
`default_nettype wire

// [tb/rivm_fetch_model.sv]
// Purpose: Fetch unit model that takes offered vectors
// Assumes: Offers are registered by the vector map
// Notes: The wait before each take is set by the bench
`timescale 1ns/10ps
`default_nettype none
module rivm_fetch_model
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic valid_i,
    input wire logic [1:0] wait_i,
    output logic ack_o
);
    logic [1:0] cnt_q;
    // Count the cycles that an offer has stood
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i || !valid_i || ack_o)
            cnt_q <= 2'h0;
        else if (cnt_q != wait_i)
            cnt_q <= cnt_q + 2'h1;
    end
    // Take a standing offer only, with a one-cycle pulse
    always_ff @(posedge clk_i)
    begin
        ack_o <= rstn_i && valid_i && !ack_o && cnt_q == wait_i;
    end
endmodule
`default_nettype wire

// [tb/tb.sv]
// Purpose: Self-checking bench for the vector map
// Assumes: Boot section start taken from the package
// Notes: Expected fetches are queued and checked when taken
`timescale 1ns/10ps
`default_nettype none
module tb;
    import rivm_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, fuse = 1'b1, en = 1'b1, we = 1'b0, ack;
    logic [24:0] req = 25'h0;
    logic [7:0] wd = 8'h00, ctl;
    logic [1:0] wt = 2'h0;
    logic [31:0] rng = 32'h35;
    logic [13:0] base;
    rivm_fetch_t fo;
    rivm_fetch_t exp_q[$];
    int fails = 0, check_count = 0;
    rivm_top rivm_top_inst (.ref_clk_i(clk), .rstn_i(rstn), .boot_reset_fuse_i(fuse),
        .irq_req_i(req), .global_irq_en_i(en), .fetch_ack_i(ack), .ctl_we_i(we),
        .ctl_wdata_i(wd), .fetch_o(fo), .mcu_control_reg_o(ctl));
    rivm_fetch_model rivm_fetch_model_inst (.clk_i(clk), .rstn_i(rstn),
        .valid_i(fo.valid), .wait_i(wt), .ack_o(ack));
    // Clock
    always #5 clk = ~clk;
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Compare each taken offer with the oldest expectation
    always @(negedge clk)
    begin
        if (rstn && fo.valid === 1'b1 && ack === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk("unasked", 1, 0);
            else
            begin
                chk("is_reset", fo.is_reset, exp_q[0].is_reset);
                chk("addr", fo.addr, exp_q[0].addr);
                if (!exp_q[0].is_reset)
                    chk("vec_idx", fo.vec_idx, exp_q[0].vec_idx);
                void'(exp_q.pop_front());
            end
        end
    end
    task automatic do_reset(input logic f);
        @(posedge clk);
        rstn <= 1'b0;
        fuse <= f;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        exp_q.push_back({1'b1, 1'b1, 5'h00, f ? 14'h0000 : RIVM_BOOT_START});
        @(negedge clk);
        chk("ctl_reset", ctl, 8'h00);
    endtask
    task automatic ctl_write(input logic [7:0] d);
        @(posedge clk);
        we <= 1'b1;
        wd <= d;
        @(posedge clk);
        we <= 1'b0;
        @(negedge clk);
        chk("ctl", ctl, d & 8'h03);
    endtask
    // Raise a pattern, drop the lowest bit as each offer is taken
    task automatic offer(input logic [24:0] p);
        logic [24:0] left;
        int n;
        left = p;
        for (int i = 0; i < 25; i++)
            if (p[i])
                exp_q.push_back({2'b10, i[4:0], base + 14'h0002 + 14'h0002 * i[13:0]});
        @(posedge clk);
        req <= p;
        wt <= 2'(xs());
        n = 0;
        while (left != 25'h0 && n < 300)
        begin
            @(negedge clk);
            n++;
            if (fo.valid === 1'b1 && ack === 1'b1)
            begin
                left = left & (left - 25'h1);
                @(posedge clk);
                req <= left;
            end
        end
        chk("pending", exp_q.size(), 0);
    endtask
    // Main sequence: every fuse and table select pairing
    initial
    begin
        for (int c = 0; c < 4; c++)
        begin
            do_reset(c[0]);
            base = c[1] ? RIVM_BOOT_START : 14'h0000;
            ctl_write((8'(xs()) & 8'hFD) | {6'h00, c[1], 1'b0});
            while (exp_q.size() != 0)
                @(posedge clk);
            @(posedge clk);
            en <= 1'b0;
            req <= 25'(xs()) | 25'h1;
            repeat (10) @(negedge clk) chk("masked", fo.valid, 0);
            @(posedge clk);
            en <= 1'b1;
            req <= 25'h0;
            repeat (3) @(posedge clk);
            for (int i = 0; i < 25; i++)
                offer((25'h1 << i) | (25'(xs()) << i));
        end
        test_done();
    end
    // Watchdog
    initial
    begin
        repeat (60000) @(posedge clk);
        fails++;
        test_done();
    end
endmodule
`default_nettype wire
